// ---- rtl/icd_channel_ctrl.sv ----
// Control logic for both channels of a PCI-to-IDE controller: DMA handshake,
// interrupt routing, address claim, prefetch limiter, descriptor decode.
// Assumes host I/O accesses are on i_clk; drive and pin inputs are async.
module icd_channel_ctrl
    import icd_pkg::*;
#(
    parameter int IDX_W = 13
)
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Configuration
    input  wire icd_irqctl_s i_irq_ctl,
    input  wire logic [3:0]  i_prog_interface_byte,
    input  wire logic        i_prefetch_en,
    input  wire logic [15:0] i_sector_size,
    input  wire logic [9:0]  i_bar0,
    input  wire logic [9:0]  i_bar1,
    input  wire logic [9:0]  i_bar2,
    input  wire logic [9:0]  i_bar3,
    // Host I/O access
    input  wire icd_io_s     i_io,
    output logic             o_claim_ch1,
    output logic             o_claim_ch2,
    output logic [7:0]       o_class_code,
    output logic [7:0]       o_subclass_code,
    output logic [7:0]       o_prog_interface_byte,
    // Prefetch
    input  wire logic        i_pf_room,
    input  wire logic        i_pf_word_done,
    output logic             o_pf_active,
    output logic [15:0]      o_sector_left,
    // Drive interrupts (pins)
    input  wire logic        i_channel_one_irq_req,
    input  wire logic        i_channel_two_irq_req,
    output logic             o_irq14,
    output logic             o_irq15,
    output logic             o_inta_n,
    // DMA handshake
    input  wire logic        i_dma_start,
    input  wire logic        i_dma_dreq,
    input  wire logic        i_data_left,
    input  wire logic        i_last_cmd_done,
    output logic             o_dma_ack_n,
    output logic             o_data_cycle,
    output logic             o_dma_busy,
    // Region descriptor fetch
    input  wire logic        i_desc_valid,
    input  wire logic [31:0] i_desc_word0,
    input  wire logic [31:0] i_desc_word1,
    input  wire logic        i_region_done,
    output icd_desc_s        o_desc,
    output logic             o_desc_fetch,
    output logic [IDX_W-1:0] o_desc_index,
    output logic             o_table_done
);

    // Every check below runs on i_clk and rests during reset
    default clocking chk_cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic dreq_s;
    logic irq1_s;
    logic irq2_s;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {i_dma_dreq, i_channel_one_irq_req,
                        i_channel_two_irq_req};
            sync2_r <= sync1_r;
        end
    end

    assign dreq_s = sync2_r[2];
    assign irq1_s = sync2_r[1];
    assign irq2_s = sync2_r[0];

    // ----------------------------------------
    // Address claim
    // ----------------------------------------
    function automatic logic hit8(input logic [9:0] a, input logic [9:0] b);
        hit8 = (a[9:3] == b[9:3]);
    endfunction

    logic ch1_native;
    logic ch2_native;
    logic ch1_leg_hit;
    logic ch2_leg_hit;
    logic ch1_nat_hit;
    logic ch2_nat_hit;
    logic ch1_data_rd;
    logic ch2_data_rd;
    logic ch1_cmd_wr;
    logic ch2_cmd_wr;

    assign ch1_native = i_prog_interface_byte[ICD_PIF_CH1_MODE];
    assign ch2_native = i_prog_interface_byte[ICD_PIF_CH2_MODE];
    // Mode bit set also turns the legacy decode off
    assign ch1_leg_hit = !ch1_native && (hit8(i_io.addr, ICD_PRI_CMD_BASE)
        || i_io.addr == ICD_PRI_CTL_ADDR);
    assign ch2_leg_hit = !ch2_native && (hit8(i_io.addr, ICD_SEC_CMD_BASE)
        || i_io.addr == ICD_SEC_CTL_ADDR);
    assign ch1_nat_hit = ch1_native && (hit8(i_io.addr, i_bar0)
        || i_io.addr == i_bar1);
    assign ch2_nat_hit = ch2_native && (hit8(i_io.addr, i_bar2)
        || i_io.addr == i_bar3);
    // Disabled device claims nothing
    assign o_claim_ch1 = i_irq_ctl.enable && i_io.valid
        && (ch1_leg_hit || ch1_nat_hit);
    assign o_claim_ch2 = i_irq_ctl.enable && i_io.valid
        && (ch2_leg_hit || ch2_nat_hit);

    assign ch1_data_rd = o_claim_ch1 && !i_io.write
        && i_io.addr[2:0] == ICD_DATA_OFS && i_io.addr != i_bar1
        && i_io.addr != ICD_PRI_CTL_ADDR;
    assign ch2_data_rd = o_claim_ch2 && !i_io.write
        && i_io.addr[2:0] == ICD_DATA_OFS && i_io.addr != i_bar3
        && i_io.addr != ICD_SEC_CTL_ADDR;
    assign ch1_cmd_wr = o_claim_ch1 && i_io.write
        && i_io.addr[2:0] == ICD_CMDREG_OFS;
    assign ch2_cmd_wr = o_claim_ch2 && i_io.write
        && i_io.addr[2:0] == ICD_CMDREG_OFS;

    // Class code reporting
    assign o_class_code = ICD_CLASS_CODE;
    assign o_subclass_code = ICD_SUBCLASS_CODE;
    assign o_prog_interface_byte = {4'h0, i_prog_interface_byte};

    // ----------------------------------------
    // Interrupt routing
    // ----------------------------------------
    logic irq1_m;
    logic irq2_m;
    logic irq14_nxt;
    logic irq15_nxt;
    logic inta_nxt;
    logic irq14_r;
    logic irq15_r;
    logic inta_n_r;

    always_comb
    begin
        irq1_m = irq1_s && !i_irq_ctl.mask_ch1;
        irq2_m = irq2_s && !i_irq_ctl.mask_ch2;
        irq14_nxt = 1'b0;
        irq15_nxt = 1'b0;
        inta_nxt = 1'b0;
        if (!i_irq_ctl.enable)
        begin
            inta_nxt = 1'b0;
        end
        else if (ch1_native && ch2_native)
        begin
            inta_nxt = !i_irq_ctl.mask_inta && (irq1_m || irq2_m);
        end
        else
        begin
            irq14_nxt = !i_irq_ctl.route0 && irq1_m;
            irq15_nxt = !i_irq_ctl.route1 && irq2_m;
            inta_nxt = !i_irq_ctl.mask_inta
                && ((i_irq_ctl.route0 && irq1_m)
                || (i_irq_ctl.route1 && irq2_m));
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            irq14_r <= 1'b0;
            irq15_r <= 1'b0;
            inta_n_r <= 1'b1;
        end
        else
        begin
            irq14_r <= irq14_nxt;
            irq15_r <= irq15_nxt;
            inta_n_r <= !inta_nxt;
        end
    end

    assign o_irq14 = irq14_r;
    assign o_irq15 = irq15_r;
    assign o_inta_n = inta_n_r;

    // ----------------------------------------
    // Prefetch with sector counter
    // ----------------------------------------
    function automatic logic is_read_cmd(input logic [7:0] c);
        is_read_cmd = c == ICD_CMD_RD_BUF || c == ICD_CMD_RD_MULT
            || c == ICD_CMD_RD_RETRY || c == ICD_CMD_RD_NORETRY;
    endfunction

    logic pf_r;
    logic pf_nxt;
    logic [15:0] sect_r;
    logic [15:0] sect_nxt;
    logic rd_cmd_wr;

    assign rd_cmd_wr = (ch1_cmd_wr || ch2_cmd_wr) && is_read_cmd(i_io.wdata);

    always_comb
    begin
        pf_nxt = pf_r;
        sect_nxt = sect_r;
        if (rd_cmd_wr)
        begin
            pf_nxt = 1'b0;
            sect_nxt = i_sector_size;
        end
        else if (pf_r && i_pf_word_done)
        begin
            if (sect_r <= 16'h0001)
            begin
                pf_nxt = 1'b0;
                sect_nxt = i_sector_size;
            end
            else
            begin
                sect_nxt = sect_r - 16'h0001;
            end
        end
        else if (!pf_r && i_prefetch_en && i_pf_room
            && (ch1_data_rd || ch2_data_rd))
        begin
            pf_nxt = 1'b1;
        end
        if (!i_prefetch_en)
        begin
            pf_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            pf_r <= 1'b0;
            sect_r <= ICD_SECTOR_RST;
        end
        else
        begin
            pf_r <= pf_nxt;
            sect_r <= sect_nxt;
        end
    end

    // No word request past the sector end, even if room remains
    assign o_pf_active = pf_r && i_pf_room;
    assign o_sector_left = sect_r;

    // ----------------------------------------
    // DMA request/acknowledge
    // ----------------------------------------
    icd_dma_e dma_r;
    icd_dma_e dma_nxt;

    always_comb
    begin
        dma_nxt = dma_r;
        case (dma_r)
            ICD_DMA_IDLE:
                if (i_dma_start) dma_nxt = ICD_DMA_WAIT;
            ICD_DMA_WAIT:
                if (dreq_s && i_data_left) dma_nxt = ICD_DMA_XFER;
            ICD_DMA_XFER:
                if (!dreq_s || !i_data_left) dma_nxt = ICD_DMA_DONE;
            ICD_DMA_DONE:
                if (i_last_cmd_done && !dreq_s)
                    dma_nxt = ICD_DMA_IDLE;
                else if (dreq_s && i_data_left)
                    dma_nxt = ICD_DMA_XFER;
            default:
                dma_nxt = ICD_DMA_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            dma_r <= ICD_DMA_IDLE;
        else
            dma_r <= dma_nxt;
    end

    // Ack held through pauses so the drive sees one burst owner
    assign o_dma_ack_n = !(dma_r == ICD_DMA_XFER || dma_r == ICD_DMA_DONE);
    assign o_data_cycle = dma_r == ICD_DMA_XFER && dreq_s && i_data_left;
    assign o_dma_busy = dma_r != ICD_DMA_IDLE;

    // ----------------------------------------
    // Region descriptor walk
    // ----------------------------------------
    logic [IDX_W-1:0] idx_r;
    logic [IDX_W-1:0] idx_nxt;
    logic have_r;
    logic have_nxt;
    logic done_r;
    logic done_nxt;
    icd_desc_s desc_r;
    icd_desc_s desc_nxt;

    always_comb
    begin
        idx_nxt = idx_r;
        have_nxt = have_r;
        done_nxt = done_r;
        desc_nxt = desc_r;
        if (i_dma_start)
        begin
            idx_nxt = '0;
            have_nxt = 1'b0;
            done_nxt = 1'b0;
        end
        else if (!have_r && !done_r && i_desc_valid)
        begin
            have_nxt = 1'b1;
            desc_nxt.base = {i_desc_word0[31:ICD_DESC_ADDR_LSB],
                1'b0};
            desc_nxt.count = {i_desc_word1[ICD_DESC_CNT_MSB:ICD_DESC_CNT_LSB],
                1'b0};
            desc_nxt.last_entry_flag = i_desc_word1[ICD_DESC_LAST_BIT];
        end
        else if (have_r && i_region_done)
        begin
            have_nxt = 1'b0;
            idx_nxt = idx_r + 1'b1;
            done_nxt = desc_r.last_entry_flag;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            idx_r <= '0;
            have_r <= 1'b0;
            done_r <= 1'b1;
            desc_r <= '0;
        end
        else
        begin
            idx_r <= idx_nxt;
            have_r <= have_nxt;
            done_r <= done_nxt;
            desc_r <= desc_nxt;
        end
    end

    assign o_desc = desc_r;
    assign o_desc_fetch = !have_r && !done_r;
    assign o_desc_index = idx_r;
    assign o_table_done = done_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    no_early_data_a: assert property (
        o_data_cycle |-> dreq_s && !o_dma_ack_n)
        else $error("data cycle without request");
    ack_follows_req_a: assert property (
        $rose(dreq_s) && dma_r == ICD_DMA_WAIT && i_data_left
        |=> !o_dma_ack_n)
        else $error("ack missing after request");
    ack_release_a: assert property (
        $rose(o_dma_ack_n) |-> !$past(dreq_s) && $past(i_last_cmd_done))
        else $error("ack dropped early");
    disabled_quiet_a: assert property (
        !i_irq_ctl.enable ##1 !$past(i_irq_ctl.enable)
        |-> o_inta_n && !o_irq14 && !o_irq15)
        else $error("irq while disabled");
    legacy_irq14_a: assert property (
        i_irq_ctl.enable && !ch1_native && !i_irq_ctl.route0
        && !i_irq_ctl.mask_ch1 && irq1_s |=> o_irq14)
        else $error("irq14 not routed");
    route_inta_a: assert property (
        i_irq_ctl.enable && !ch1_native && i_irq_ctl.route0
        && !i_irq_ctl.mask_inta && irq1_s && !i_irq_ctl.mask_ch1
        |=> !o_inta_n && !o_irq14)
        else $error("route option 0 failed");
    native_mask_a: assert property (
        ch1_native && ch2_native && i_irq_ctl.mask_inta |=> o_inta_n)
        else $error("inta not masked");
    legacy_decode_a: assert property (
        i_irq_ctl.enable && i_io.valid && !ch2_native
        && i_io.addr == ICD_SEC_CTL_ADDR |-> o_claim_ch2)
        else $error("secondary control miss");
    native_ignore_a: assert property (
        ch1_native && hit8(i_io.addr, ICD_PRI_CMD_BASE)
        && !ch1_nat_hit |-> !o_claim_ch1)
        else $error("native claimed legacy");
    sector_limit_a: assert property (
        pf_r && i_pf_word_done && sect_r == 16'h0001 && !rd_cmd_wr
        |=> !pf_r && sect_r == $past(i_sector_size))
        else $error("prefetch past sector");
    cmd_reload_a: assert property (
        rd_cmd_wr |=> !pf_r ##0 sect_r == $past(i_sector_size))
        else $error("read command no reload");
    last_entry_a: assert property (
        have_r && i_region_done && !desc_r.last_entry_flag && !i_dma_start
        |=> o_desc_fetch)
        else $error("walk stopped early");

    dma_burst_c: cover property (
        dma_r == ICD_DMA_WAIT ##1 o_data_cycle[*3]
        ##[1:40] $rose(o_dma_ack_n));
    prefetch_c: cover property (
        $rose(pf_r) ##[1:40] $fell(pf_r));
    native_inta_c: cover property (
        ch1_native && ch2_native && !o_inta_n);
    table_end_c: cover property (
        $rose(o_table_done));

endmodule

// ---- rtl/icd_pkg.sv ----
// Package for the IDE channel control block: constants and carriers.
// Assumes a single 50 MHz clock domain and plain-port control bits.
package icd_pkg;

    // ----------------------------------------
    // Legacy addresses (10-bit I/O)
    // ----------------------------------------
    localparam logic [9:0] ICD_PRI_CMD_BASE = 10'h1F0;
    localparam logic [9:0] ICD_PRI_CTL_ADDR = 10'h3F6;
    localparam logic [9:0] ICD_SEC_CMD_BASE = 10'h170;
    localparam logic [9:0] ICD_SEC_CTL_ADDR = 10'h376;
    localparam logic [2:0] ICD_DATA_OFS = 3'h0;
    localparam logic [2:0] ICD_CMDREG_OFS = 3'h7;

    // ----------------------------------------
    // Class code bytes
    // ----------------------------------------
    localparam logic [7:0] ICD_CLASS_CODE = 8'h01;
    localparam logic [7:0] ICD_SUBCLASS_CODE = 8'h01;
    localparam int ICD_PIF_CH1_MODE = 0;
    localparam int ICD_PIF_CH2_MODE = 2;

    // ----------------------------------------
    // Monitored drive read commands
    // ----------------------------------------
    localparam logic [7:0] ICD_CMD_RD_BUF = 8'hE4;
    localparam logic [7:0] ICD_CMD_RD_MULT = 8'hC4;
    localparam logic [7:0] ICD_CMD_RD_RETRY = 8'h20;
    localparam logic [7:0] ICD_CMD_RD_NORETRY = 8'h21;

    // ----------------------------------------
    // Region descriptor layout
    // ----------------------------------------
    localparam int ICD_DESC_ADDR_LSB = 1;
    localparam int ICD_DESC_CNT_LSB = 1;
    localparam int ICD_DESC_CNT_MSB = 15;
    localparam int ICD_DESC_LAST_BIT = 31;
    localparam int ICD_DESC_MAX = 8192;
    localparam logic [15:0] ICD_SECTOR_RST = 16'h0100;

    typedef enum logic [1:0] {
        ICD_DMA_IDLE = 2'b00,
        ICD_DMA_WAIT = 2'b01,
        ICD_DMA_XFER = 2'b10,
        ICD_DMA_DONE = 2'b11
    } icd_dma_e;

    // Host I/O access seen on the PCI side
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [9:0] addr;
        logic [7:0] wdata;
    } icd_io_s;

    // Interrupt routing controls
    typedef struct packed {
        logic enable;
        logic mask_inta;
        logic mask_ch1;
        logic mask_ch2;
        logic route0;
        logic route1;
    } icd_irqctl_s;

    // Decoded region descriptor
    typedef struct packed {
        logic [31:0] base;
        logic [15:0] count;
        logic        last_entry_flag;
    } icd_desc_s;

endpackage

// ---- verification/icd_drive_model.sv ----
// Drive-side model: raises the DMA request pin and counts data cycles.
// Assumes i_go is a one-cycle pulse on i_clk from the bench.
module icd_drive_model
(
    // Clock and control
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [3:0] i_delay,
    input wire logic [3:0] i_words,
    // Cable side
    input wire logic i_data_cycle,
    output logic o_dma_dreq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_r = 4'h0;
    logic [3:0] left_r = 4'h0;
    logic dreq_r = 1'b0;

    assign o_dma_dreq = dreq_r;

    // Slow start so the controller must hold off
    always @(posedge i_clk)
    begin
        if (i_go)
        begin
            wait_r <= i_delay;
            left_r <= i_words;
        end
        else if (wait_r != 4'h0)
        begin
            wait_r <= wait_r - 4'h1;
            dreq_r <= (wait_r == 4'h1);
        end
        else if (dreq_r && i_data_cycle)
        begin
            left_r <= left_r - 4'h1;
            dreq_r <= (left_r != 4'h1);
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the IDE channel control block.
// Assumes one 50 MHz clock; inputs change on the falling edge.
module tb_top
    import icd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----
    // Stimulus and observation
    // ----
    logic clk, rst, pf_en, pf_room, pf_wd, irq1, irq2;
    logic dstart, dleft, lcd, dvalid, rdone, go, dreq;
    logic claim1, claim2, pfa, i14, i15, inta_n, ack_n, dcyc, busy;
    logic dfetch, tdone;
    logic [1:0] cl;
    logic [3:0] prog_interface_byte;
    logic [7:0] cls, sub, pifo;
    logic [9:0] bar0, bar1, bar2, bar3;
    logic [12:0] didx;
    logic [15:0] ssize, sleft;
    logic [31:0] w0, w1;
    icd_irqctl_s ctl;
    icd_io_s io;
    icd_desc_s desc;
    logic [7:0] cmds [4] = '{ICD_CMD_RD_BUF, ICD_CMD_RD_MULT,
                             ICD_CMD_RD_RETRY, ICD_CMD_RD_NORETRY};
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int bad = 0;
    int ncyc = 0;
    int seen = 0;

    icd_channel_ctrl dut (
        .i_clk(clk), .i_sys_rst(rst), .i_irq_ctl(ctl),
        .i_prog_interface_byte(prog_interface_byte), .i_prefetch_en(pf_en),
        .i_sector_size(ssize), .i_bar0(bar0), .i_bar1(bar1),
        .i_bar2(bar2), .i_bar3(bar3), .i_io(io), .o_claim_ch1(claim1),
        .o_claim_ch2(claim2), .o_class_code(cls), .o_subclass_code(sub),
        .o_prog_interface_byte(pifo), .i_pf_room(pf_room),
        .i_pf_word_done(pf_wd), .o_pf_active(pfa), .o_sector_left(sleft),
        .i_channel_one_irq_req(irq1), .i_channel_two_irq_req(irq2),
        .o_irq14(i14), .o_irq15(i15), .o_inta_n(inta_n),
        .i_dma_start(dstart), .i_dma_dreq(dreq), .i_data_left(dleft),
        .i_last_cmd_done(lcd), .o_dma_ack_n(ack_n), .o_data_cycle(dcyc),
        .o_dma_busy(busy), .i_desc_valid(dvalid), .i_desc_word0(w0),
        .i_desc_word1(w1), .i_region_done(rdone), .o_desc(desc),
        .o_desc_fetch(dfetch), .o_desc_index(didx), .o_table_done(tdone)
    );

    icd_drive_model drive (
        .i_clk(clk), .i_go(go), .i_delay(4'h6), .i_words(4'h4),
        .i_data_cycle(dcyc), .o_dma_dreq(dreq)
    );

    // ----
    // Clock, watchdog and cable monitor
    // ----
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            $display("unexpected at %0t: timeout", $time);
            print_verdict();
        end
    end

    always @(posedge clk)
    begin
        if (dcyc && (ack_n || seen == 0))
            bad++;
        if (dcyc)
            ncyc++;
        if (dreq)
            seen = 1;
    end

    // ----
    // Shared tasks
    // ----
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(negedge clk);
        io = '{1'b1, w, a, d};
        #2 cl = {claim2, claim1};
        @(negedge clk);
        io.valid = 1'b0;
    endtask

    task dec(input logic [9:0] a, input logic [1:0] e);
        acc(1'b0, a, 8'h00);
        chk(32'(cl), 32'(e), "claim");
    endtask

    // Pins pass two synchroniser flops, so allow four cycles
    task ir(input logic [5:0] c, input logic [3:0] p, input logic r1,
            input logic r2, input logic [2:0] e);
        @(negedge clk);
        ctl = c;
        prog_interface_byte = p;
        irq1 = r1;
        irq2 = r2;
        repeat (4) @(negedge clk);
        chk(32'({i14, i15, inta_n}), 32'(e), "irq routing");
    endtask

    task wd;
        @(negedge clk);
        pf_wd = 1'b1;
        @(negedge clk);
        pf_wd = 1'b0;
    endtask

    task dgo;
        @(negedge clk);
        dstart = 1'b1;
        go = 1'b1;
        @(negedge clk);
        dstart = 1'b0;
        go = 1'b0;
    endtask

    task print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----
    // Tests
    // ----
    initial
    begin
        rst = 1'b1;
        ctl = '0;
        prog_interface_byte = 4'h0;
        pf_en = 1'b0;
        ssize = 16'h0003;
        bar0 = 10'h200;
        bar1 = 10'h20A;
        bar2 = 10'h300;
        bar3 = 10'h30A;
        io = '0;
        pf_room = 1'b1;
        pf_wd = 1'b0;
        irq1 = 1'b0;
        irq2 = 1'b0;
        dstart = 1'b0;
        dleft = 1'b1;
        lcd = 1'b0;
        dvalid = 1'b0;
        w0 = '0;
        w1 = '0;
        rdone = 1'b0;
        go = 1'b0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(32'(sleft), 32'(ICD_SECTOR_RST), "sector reset");
        chk({16'h0, cls, sub}, 32'h0101, "class");
        $display("test reset done");

        ir(6'b011111, 4'h0, 1'b1, 1'b1, 3'b001);
        ir(6'b100000, 4'h0, 1'b1, 1'b0, 3'b101);
        ir(6'b100000, 4'h0, 1'b0, 1'b1, 3'b011);
        ir(6'b101000, 4'h0, 1'b1, 1'b1, 3'b011);
        ir(6'b100100, 4'h0, 1'b1, 1'b1, 3'b101);
        ir(6'b100010, 4'h0, 1'b1, 1'b1, 3'b010);
        ir(6'b100001, 4'h0, 1'b0, 1'b1, 3'b000);
        ir(6'b100011, 4'h0, 1'b0, 1'b1, 3'b000);
        ir(6'b100011, 4'h0, 1'b0, 1'b0, 3'b001);
        ir(6'b100000, 4'h5, 1'b1, 1'b0, 3'b000);
        ir(6'b101000, 4'h5, 1'b1, 1'b0, 3'b001);
        ir(6'b110000, 4'h5, 1'b1, 1'b1, 3'b001);
        ir(6'b011111, 4'h5, 1'b1, 1'b1, 3'b001);
        $display("test interrupts done");

        dec(10'h1F0, 2'b00);
        ctl = 6'b100000;
        prog_interface_byte = 4'h0;
        dec(10'h1F0, 2'b01);
        dec(10'h1F7, 2'b01);
        dec(10'h3F6, 2'b01);
        dec(10'h1F8, 2'b00);
        dec(10'h177, 2'b10);
        dec(10'h376, 2'b10);
        dec(10'h3F7, 2'b00);
        dec(10'h200, 2'b00);
        prog_interface_byte = 4'h1;
        dec(10'h1F0, 2'b00);
        dec(10'h207, 2'b01);
        dec(10'h20A, 2'b01);
        dec(10'h170, 2'b10);
        chk(32'(pifo), 32'h01, "interface byte");
        prog_interface_byte = 4'h4;
        dec(10'h170, 2'b00);
        dec(10'h300, 2'b10);
        dec(10'h30A, 2'b10);
        prog_interface_byte = 4'h0;
        $display("test decode done");

        pf_en = 1'b1;
        acc(1'b1, 10'h1F7, ICD_CMD_RD_BUF);
        chk(32'(sleft), 32'h3, "reload");
        acc(1'b0, 10'h1F0, 8'h00);
        chk(32'(pfa), 32'h1, "start");
        repeat (3) wd();
        chk(32'(pfa), 32'h0, "sector end");
        chk(32'(sleft), 32'h3, "expiry reload");
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b0, i[0] ? 10'h170 : 10'h1F0, 8'h00);
            wd();
            chk(32'(sleft), 32'h2, "count");
            acc(1'b1, i[0] ? 10'h177 : 10'h1F7, cmds[i]);
            chk(32'(pfa), 32'h0, "cmd stop");
            chk(32'(sleft), 32'h3, "cmd reload");
        end
        pf_room = 1'b0;
        acc(1'b0, 10'h1F0, 8'h00);
        pf_room = 1'b1;
        #2 chk(32'(pfa), 32'h0, "no room");
        pf_en = 1'b0;
        $display("test prefetch done");

        // DMA handshake and region walk share one start
        dgo();
        chk(32'({dfetch, tdone}), 32'h2, "fetch");
        dvalid = 1'b1;
        w0 = 32'h1234_5677;
        w1 = 32'h7FFF_0201;
        @(negedge clk);
        dvalid = 1'b0;
        chk(desc.base, 32'h1234_5676, "base");
        chk(32'(desc[16:0]), 32'h400, "w1");
        rdone = 1'b1;
        @(negedge clk);
        rdone = 1'b0;
        dvalid = 1'b1;
        w0 = 32'h0001_FFF0;
        w1 = 32'h8000_0010;
        @(negedge clk);
        dvalid = 1'b0;
        chk(32'({didx, tdone}), 32'h2, "next region");
        chk(32'(desc[16:0]), 32'h21, "last");
        chk(desc.base, 32'h0001_FFF0, "aligned base");
        rdone = 1'b1;
        @(negedge clk);
        rdone = 1'b0;
        @(negedge clk);
        chk(32'({didx, tdone}), 32'h5, "table end");
        for (int i = 0; i < 40 && !(seen == 1 && !dreq); i++)
            @(negedge clk);
        repeat (6) @(negedge clk);
        chk(32'({ack_n, busy}), 32'h1, "ack held");
        lcd = 1'b1;
        for (int i = 0; i < 10 && !ack_n; i++)
            @(negedge clk);
        chk(32'({ack_n, busy}), 32'h2, "ack drop");
        chk(32'(bad), 32'h0, "early cycle");
        chk(32'(ncyc >= 4), 32'h1, "cycles");
        lcd = 1'b0;
        // Second burst: data runs out, then the drive resumes
        dgo();
        for (int i = 0; i < 20 && ack_n; i++)
            @(negedge clk);
        @(negedge clk);
        dleft = 1'b0;
        lcd = 1'b1;
        #2 chk(32'(dcyc), 32'h0, "no data left");
        repeat (3) @(negedge clk);
        chk(32'({ack_n, busy}), 32'h1, "ack under request");
        dleft = 1'b1;
        for (int i = 0; i < 30 && !ack_n; i++)
            @(negedge clk);
        chk(32'({ack_n, busy, drive.left_r}), 32'h20, "resume");
        lcd = 1'b0;
        $display("test dma done");
        print_verdict();
    end
endmodule
